// >>> inc/irgc_cfg.svh
// Purpose: offsets, reset values and field positions of the ir/gpio config bank
// Assumes: included by the design module only; the package does not include it
// Notes: definitions only
`ifndef IRGC_CFG_SVH
`define IRGC_CFG_SVH
`define IRGC_IDX_TIMEOUT 8'h2d
`define IRGC_IDX_SELA 8'h2e
`define IRGC_IDX_SELB 8'h2f
`define IRGC_IDX_RTBASE 8'h30
`define IRGC_IDX_GPDIR 8'h31
`define IRGC_RST_TIMEOUT 8'h03
`define IRGC_RST_ZERO 8'h00
`define IRGC_RTBASE_MASK 8'hfe
`define IRGC_GPDIR_MASK 8'hce
`define IRGC_STEP_NS 100000
`define IRGC_CLK_NS 100
`define IRGC_SEL_OFS_A 3'h5
`define IRGC_SEL_OFS_B 3'h6
`define IRGC_TO_OFS 3'h1
`endif

// >>> inc/irgc_pkg.sv
// Purpose: types of the ir/gpio config bank
// Assumes: nothing
// Notes: constants live in irgc_cfg.svh
package irgc_pkg;
    typedef enum logic [1:0] {irgc_idle, irgc_count, irgc_done} irgc_to_st_t;
    typedef struct packed {
        logic [7:0] timeout;
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        logic [7:0] rt_base;
        logic [7:0] rd_data;
        logic [7:0] rt_offset;
        logic rt_hit;
        logic fir_en;
        irgc_to_st_t to_st;
        logic [7:0] to_units;
        logic [13:0] to_cyc;
        logic to_expired;
    } irgc_main_t;
endpackage

// >>> logic/irgc_regs.sv
// Purpose: config registers for ir turnaround, software selects,
//          runtime block base decode and gpio direction one
// Assumes: config_index_register and config state come from the host decoder
// Notes: two resets: main supply and standby supply, both active low
`include "irgc_cfg.svh"
module irgc_regs
    import irgc_pkg::*;
#(
    parameter int CLK_NS = `IRGC_CLK_NS
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic stby_rst_b_i,
    input wire logic cfg_state_i,
    input wire logic [7:0] config_index_register_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_wdata_i,
    output logic [7:0] cfg_rdata_o,
    input wire logic eng_to_wr_i,
    input wire logic [7:0] eng_to_wdata_i,
    input wire logic eng_sel_wr_i,
    input wire logic [2:0] eng_sel_ofs_i,
    input wire logic [7:0] eng_sel_wdata_i,
    input wire logic eng_soft_rst_i,
    input wire logic [7:0] fir_base_i,
    input wire logic to_start_i,
    output logic to_expired_o,
    output logic [7:0] ir_turnaround_timeout_o,
    output logic [7:0] ir_software_select_a_o,
    output logic [7:0] ir_software_select_b_o,
    output logic fast_ir_engine_en_o,
    input wire logic [15:0] io_addr_i,
    input wire logic io_cycle_i,
    output logic runtime_sel_o,
    output logic [4:0] runtime_offset_o,
    output logic wake_event_status_sel_o,
    output logic gpio_pin_11_dir_o,
    output logic gpio_pin_12_dir_o,
    output logic gpio_pin_13_dir_o,
    output logic gpio_pin_16_dir_o,
    output logic gpio_pin_17_dir_o
);
    localparam int STEP_CYC_RAW = `IRGC_STEP_NS / CLK_NS;
    localparam logic [13:0] STEP_CYC =
        (STEP_CYC_RAW < 1) ? 14'h0001 : 14'(STEP_CYC_RAW);

    // reset release through two flops for each supply domain
    logic [1:0] rst_sync;
    logic [1:0] stby_sync;
    logic rst_b;
    logic stby_b;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) rst_sync <= 2'h0;
        else rst_sync <= {rst_sync[0], 1'b1};
    end
    always_ff @(posedge core_clk_i or negedge stby_rst_b_i) begin
        if (!stby_rst_b_i) stby_sync <= 2'h0;
        else stby_sync <= {stby_sync[0], 1'b1};
    end
    assign rst_b = rst_sync[1];
    assign stby_b = stby_sync[1];

    // io address pins come from outside: two flops before decode
    // each bit crosses alone; the host holds an address for several
    // cycles, so a skewed bit can spoil at most one decode result
    logic [16:0] io_s1;
    logic [16:0] io_s2;
    always_ff @(posedge core_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            io_s1 <= 17'h00000;
            io_s2 <= 17'h00000;
        end else begin
            io_s1 <= {io_cycle_i, io_addr_i};
            io_s2 <= io_s1;
        end
    end

    irgc_main_t st;
    irgc_main_t next_st;
    logic [7:0] gp_dir;
    logic [7:0] next_gp_dir;
    logic acc;

    assign acc = cfg_state_i;

    // register updates, decode and timeout counter
    always_comb begin
        next_st = st;
        next_st.rd_data = `IRGC_RST_ZERO;
        // config writes and engine writes share one storage per value,
        // so the two views can never diverge; engine writes go first
        // and a config write to the same value in that cycle wins,
        // while one to another value leaves the engine write intact
        if (eng_to_wr_i) begin
            next_st.timeout = eng_to_wdata_i;
        end
        if (eng_sel_wr_i) begin
            if (eng_sel_ofs_i == `IRGC_SEL_OFS_A)
                next_st.sel_a = eng_sel_wdata_i;
            else if (eng_sel_ofs_i == `IRGC_SEL_OFS_B)
                next_st.sel_b = eng_sel_wdata_i;
        end
        if (acc && cfg_wr_i) begin
            case (config_index_register_i)
                `IRGC_IDX_TIMEOUT: next_st.timeout = cfg_wdata_i;
                `IRGC_IDX_SELA: next_st.sel_a = cfg_wdata_i;
                `IRGC_IDX_SELB: next_st.sel_b = cfg_wdata_i;
                `IRGC_IDX_RTBASE:
                    next_st.rt_base = cfg_wdata_i & `IRGC_RTBASE_MASK;
                default: ;
            endcase
        end
        // eng_soft_rst_i deliberately not used on stored values
        if (acc && cfg_rd_i) begin
            case (config_index_register_i)
                `IRGC_IDX_TIMEOUT: next_st.rd_data = next_st.timeout;
                `IRGC_IDX_SELA: next_st.rd_data = next_st.sel_a;
                `IRGC_IDX_SELB: next_st.rd_data = next_st.sel_b;
                `IRGC_IDX_RTBASE:
                    next_st.rd_data = next_st.rt_base;
                `IRGC_IDX_GPDIR: next_st.rd_data = next_gp_dir;
                default: next_st.rd_data = `IRGC_RST_ZERO;
            endcase
        end
        // runtime decode; base field zero in rt_base bits 7:4 disables it
        next_st.rt_hit = io_s2[16] && (io_s2[15:12] == 4'h0)
            && (io_s2[11:5] == st.rt_base[7:1])
            && (st.rt_base[7:4] != 4'h0);
        next_st.rt_offset = {3'h0, io_s2[4:0]};
        next_st.fir_en = (fir_base_i[7:5] != 3'h0);
        // turnaround timer: timeout units of 100 us each
        next_st.to_expired = 1'b0;
        case (st.to_st)
            irgc_idle: begin
                if (to_start_i) begin
                    next_st.to_units = st.timeout;
                    next_st.to_cyc = STEP_CYC;
                    next_st.to_st = irgc_count;
                end
            end
            irgc_count: begin
                if (eng_soft_rst_i) begin
                    next_st.to_st = irgc_idle;
                end else if (st.to_units == 8'h00) begin
                    next_st.to_st = irgc_done;
                end else if (st.to_cyc == 14'h0001) begin
                    next_st.to_cyc = STEP_CYC;
                    next_st.to_units = st.to_units - 8'h01;
                end else begin
                    next_st.to_cyc = st.to_cyc - 14'h0001;
                end
            end
            irgc_done: begin
                next_st.to_expired = 1'b1;
                next_st.to_st = irgc_idle;
            end
            default: next_st.to_st = irgc_idle;
        endcase
    end

    // gpio direction lives on standby supply, kept apart from main state
    always_comb begin
        next_gp_dir = gp_dir;
        if (acc && cfg_wr_i
            && config_index_register_i == `IRGC_IDX_GPDIR)
            next_gp_dir = cfg_wdata_i & `IRGC_GPDIR_MASK;
    end

    always_ff @(posedge core_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.timeout <= `IRGC_RST_TIMEOUT;
            st.sel_a <= `IRGC_RST_ZERO;
            st.sel_b <= `IRGC_RST_ZERO;
            st.rt_base <= `IRGC_RST_ZERO;
            st.to_st <= irgc_idle;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge core_clk_i or negedge stby_b) begin
        if (!stby_b) gp_dir <= `IRGC_RST_ZERO;
        else gp_dir <= next_gp_dir;
    end

    assign cfg_rdata_o = st.rd_data;
    assign ir_turnaround_timeout_o = st.timeout;
    assign ir_software_select_a_o = st.sel_a;
    assign ir_software_select_b_o = st.sel_b;
    assign fast_ir_engine_en_o = st.fir_en;
    assign runtime_sel_o = st.rt_hit;
    assign runtime_offset_o = st.rt_offset[4:0];
    assign wake_event_status_sel_o = st.rt_hit && (st.rt_offset == 8'h00);
    assign to_expired_o = st.to_expired;
    assign gpio_pin_11_dir_o = gp_dir[1];
    assign gpio_pin_12_dir_o = gp_dir[2];
    assign gpio_pin_13_dir_o = gp_dir[3];
    assign gpio_pin_16_dir_o = gp_dir[6];
    assign gpio_pin_17_dir_o = gp_dir[7];

    a_write_access: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (!cfg_state_i) |=> $stable(st.timeout) || $past(eng_to_wr_i))
        else $error("timeout changed outside config state");
    a_timeout_write: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (cfg_state_i && cfg_wr_i
         && config_index_register_i == `IRGC_IDX_TIMEOUT)
        |=> ir_turnaround_timeout_o == $past(cfg_wdata_i))
        else $error("timeout write lost");
    a_softrst_keep: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (eng_soft_rst_i && !cfg_wr_i && !eng_to_wr_i)
        |=> $stable(st.timeout))
        else $error("soft reset altered timeout");
    a_sela_mirror: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (eng_sel_wr_i && eng_sel_ofs_i == `IRGC_SEL_OFS_A && !cfg_wr_i)
        |=> ir_software_select_a_o == $past(eng_sel_wdata_i))
        else $error("select a mirror broken");
    a_selb_mirror: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (eng_sel_wr_i && eng_sel_ofs_i == `IRGC_SEL_OFS_B && !cfg_wr_i)
        |=> ir_software_select_b_o == $past(eng_sel_wdata_i))
        else $error("select b mirror broken");
    a_base_reserved: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        st.rt_base[0] == 1'b0)
        else $error("base reserved bit set");
    a_rt_disabled: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (st.rt_base[7:4] == 4'h0) |=> !runtime_sel_o)
        else $error("runtime decode while disabled");
    a_rt_upper: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        runtime_sel_o |-> $past(io_s2[15:12]) == 4'h0)
        else $error("runtime decode with high address");
    a_gpdir_reserved: assert property (
        @(posedge core_clk_i) disable iff (!stby_b)
        (gp_dir & ~`IRGC_GPDIR_MASK) == 8'h00)
        else $error("direction reserved bit set");
    a_fir_disable: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (fir_base_i[7:5] == 3'h0) |=> !fast_ir_engine_en_o)
        else $error("engine enabled with zero base");
    a_to_length: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (st.to_st == irgc_idle && to_start_i && st.timeout == 8'h00)
        |=> ##1 st.to_st == irgc_done)
        else $error("zero timeout not immediate");

    // read path, config write, decode, timer and reset-domain checks
    a_read_refused: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (!cfg_state_i) |=> cfg_rdata_o == 8'h00)
        else $error("read answered outside config state");
    a_read_timeout: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (cfg_state_i && cfg_rd_i
         && config_index_register_i == `IRGC_IDX_TIMEOUT)
        |=> cfg_rdata_o == ir_turnaround_timeout_o)
        else $error("timeout read differs from engine copy");
    a_base_readback: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (cfg_state_i && cfg_rd_i
         && config_index_register_i == `IRGC_IDX_RTBASE)
        |=> cfg_rdata_o == st.rt_base)
        else $error("base read differs from stored base");
    a_sela_cfg: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (cfg_state_i && cfg_wr_i
         && config_index_register_i == `IRGC_IDX_SELA)
        |=> ir_software_select_a_o == $past(cfg_wdata_i))
        else $error("select a config write not mirrored");
    a_selb_cfg: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (cfg_state_i && cfg_wr_i
         && config_index_register_i == `IRGC_IDX_SELB)
        |=> ir_software_select_b_o == $past(cfg_wdata_i))
        else $error("select b config write not mirrored");
    a_offset_pass: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        runtime_sel_o |-> runtime_offset_o == $past(io_s2[4:0]))
        else $error("runtime offset differs from address");
    a_rt_match: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        runtime_sel_o |-> $past(io_s2[11:5]) == $past(st.rt_base[7:1]))
        else $error("runtime decode with wrong base");
    a_gpdir_write: assert property (
        @(posedge core_clk_i) disable iff (!stby_b)
        (cfg_state_i && cfg_wr_i
         && config_index_register_i == `IRGC_IDX_GPDIR)
        |=> gpio_pin_11_dir_o == $past(cfg_wdata_i[1])
            && gpio_pin_17_dir_o == $past(cfg_wdata_i[7]))
        else $error("direction write not on pins");
    a_gpdir_main: assert property (
        @(posedge core_clk_i) disable iff (!stby_b)
        (!rst_b && !cfg_wr_i) |=> $stable(gp_dir))
        else $error("main reset altered direction");
    a_to_reload: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (st.to_st == irgc_idle && to_start_i)
        |=> st.to_units == $past(st.timeout))
        else $error("timer not loaded from timeout");
    a_fir_enable: assert property (
        @(posedge core_clk_i) disable iff (!rst_b)
        (fir_base_i[7:5] != 3'h0) |=> fast_ir_engine_en_o)
        else $error("engine disabled with nonzero base");
endmodule // irgc_regs

// >>> tb/irgc_host.sv
// Purpose: host model issuing config cycles and io addresses
// Assumes: driven at the falling clock edge
// Notes: released data shows the inverse of the last value
module irgc_host (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic cfg_state_o,
    output logic [7:0] idx_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o,
    output logic [15:0] io_addr_o,
    output logic io_cycle_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle: outside config state, no io cycle
    initial begin
        {cfg_state_o, idx_o, wr_o, rd_o, wdata_o} = '0;
        io_addr_o = 16'hffff;
        io_cycle_o = 1'b0;
    end
    // one config cycle; cs low gives a cycle the device must refuse
    task automatic xfer(input logic cs, input logic w, input logic [7:0] i,
                        input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_i);
        cfg_state_o = cs;
        idx_o = i;
        wr_o = w;
        rd_o = !w;
        wdata_o = d;
        @(negedge clk_i);
        q = rdata_i;
        {wr_o, rd_o} = 2'b00;
        wdata_o = ~d; // stale data must not look valid
        cfg_state_o = 1'b0;
    endtask
    // runtime io access; held long enough for the synchroniser
    // c low shows an address on the pins that is not an io cycle
    task automatic io(input logic [15:0] a, input logic c);
        @(negedge clk_i);
        io_addr_o = a;
        io_cycle_o = c;
        repeat (4) @(negedge clk_i);
    endtask
endmodule // irgc_host

// >>> tb/test_ir_runtime_gpio_config_regs.sv
// Purpose: self-checking bench for the ir/gpio config bank
// Assumes: host model drives config cycles, engine side driven here
// Notes: CLK_NS raised so one 100 us step is ten cycles
module test_ir_runtime_gpio_config_regs
    import irgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b = 1'b0, stby_b = 1'b0, to_start = 1'b0;
    logic e_to_wr = 1'b0, e_sel_wr = 1'b0, e_srst = 1'b0;
    logic [7:0] e_to_d = 8'h00, e_sel_d = 8'h00, fir_base = 8'h00, q;
    logic [2:0] e_ofs = 3'h5;
    logic cs, wr, rd, io_cyc, to_exp, fir_en, rt_sel, wake_sel;
    logic [7:0] idx, wd, rdata, to_o, sa_o, sb_o;
    logic [15:0] io_a;
    logic [4:0] rt_ofs, dir;
    // near misses, a high-page alias of base 0x21 and two wake hits
    logic [15:0] addr[5] = '{16'h0105, 16'h0200, 16'hf203, 16'h0125,
        16'h0fe0};
    logic [7:0] bases[3] = '{8'h21, 8'h03, 8'hff};
    int num_errors = 0, tests_run = 0, cyc = 0, n;
    int m[5];
    int msk[5] = '{255, 255, 255, 254, 206};
    irgc_host host (.clk_i(clk), .rdata_i(rdata), .cfg_state_o(cs),
        .idx_o(idx), .wr_o(wr), .rd_o(rd), .wdata_o(wd), .io_addr_o(io_a),
        .io_cycle_o(io_cyc));
    irgc_regs #(.CLK_NS(10000)) DUT (.core_clk_i(clk), .rst_b_i(rst_b),
        .stby_rst_b_i(stby_b), .cfg_state_i(cs),
        .config_index_register_i(idx), .cfg_wr_i(wr), .cfg_rd_i(rd),
        .cfg_wdata_i(wd), .cfg_rdata_o(rdata), .eng_to_wr_i(e_to_wr),
        .eng_to_wdata_i(e_to_d), .eng_sel_wr_i(e_sel_wr),
        .eng_sel_ofs_i(e_ofs), .eng_sel_wdata_i(e_sel_d),
        .eng_soft_rst_i(e_srst), .fir_base_i(fir_base),
        .to_start_i(to_start), .to_expired_o(to_exp),
        .ir_turnaround_timeout_o(to_o), .ir_software_select_a_o(sa_o),
        .ir_software_select_b_o(sb_o), .fast_ir_engine_en_o(fir_en),
        .io_addr_i(io_a), .io_cycle_i(io_cyc), .runtime_sel_o(rt_sel),
        .runtime_offset_o(rt_ofs), .wake_event_status_sel_o(wake_sel),
        .gpio_pin_11_dir_o(dir[0]), .gpio_pin_12_dir_o(dir[1]),
        .gpio_pin_13_dir_o(dir[2]), .gpio_pin_16_dir_o(dir[3]),
        .gpio_pin_17_dir_o(dir[4]));
    // clock, and a hang guard well above the expected few hundred cycles
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [4:0] got, input logic [4:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_m(input int i, input logic [7:0] d);
        host.xfer(1'b1, 1'b1, 8'(8'h2d + i), d, q);
        m[i] = d;
    endtask
    task automatic rd_m(input int i);
        host.xfer(1'b1, 1'b0, 8'(8'h2d + i), 8'h00, q);
        chk_reg(q, 8'(m[i] & msk[i]));
    endtask
    task automatic outs;
        chk_reg(to_o, 8'(m[0]));
        chk_reg(sa_o, 8'(m[1]));
        chk_reg(sb_o, 8'(m[2]));
        chk_pin(dir, {m[4][7:6], m[4][3:1]});
    endtask
    // expected decode worked out from the model's base field
    task automatic dec(input logic [15:0] a);
        logic hit;
        hit = a[15:12] == 0 && a[11:5] == m[3][7:1] && m[3][7:4] != 0;
        host.io(a, 1'b1);
        chk_pin(5'(rt_sel), 5'(hit));
        chk_pin(5'(wake_sel), 5'(hit && a[4:0] == 0));
        if (hit) chk_pin(rt_ofs, a[4:0]);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic do_rst(input logic main);
        @(negedge clk);
        if (main) rst_b = 1'b0;
        else stby_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        stby_b = 1'b1;
        repeat (4) @(negedge clk);
        if (main) m = '{3, 0, 0, 0, m[4]};
        else m[4] = 0;
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // main sequence
    initial begin
        void'($urandom(32'ha92d));
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        stby_b = 1'b1;
        repeat (4) @(negedge clk);
        m = '{3, 0, 0, 0, 0};
        for (int i = 0; i < 5; i++) rd_m(i);
        repeat (4) begin
            for (int i = 0; i < 5; i++) begin
                wr_m(i, 8'($urandom));
                rd_m(i);
            end
            outs();
        end
        // outside config state nothing moves; unknown index reads zero
        host.xfer(1'b0, 1'b1, 8'h2d, 8'(~m[0]), q);
        rd_m(0);
        host.xfer(1'b0, 1'b0, 8'h2d, 8'h00, q);
        chk_reg(q, 8'h00);
        host.xfer(1'b1, 1'b0, 8'h2c, 8'h00, q);
        chk_reg(q, 8'h00);
        // engine-side writes show on config reads and outputs; soft reset keeps the engine timeout write
        e_to_d = 8'($urandom);
        pulse(e_to_wr);
        m[0] = e_to_d;
        rd_m(0);
        pulse(e_srst);
        rd_m(0);
        for (int k = 1; k < 3; k++) begin
            e_ofs = 3'(4 + k);
            e_sel_d = 8'($urandom);
            pulse(e_sel_wr);
            m[k] = e_sel_d;
            rd_m(k);
        end
        outs();
        foreach (bases[b]) begin
            wr_m(3, bases[b]);
            dec({4'h0, bases[b][7:1], 5'h03});
            foreach (addr[j]) dec(addr[j]);
        end
        // matching address without an io cycle must not decode
        host.io(16'h0fe0, 1'b0);
        chk_pin(5'(rt_sel), 5'h00);
        fir_base = 8'h20;
        repeat (2) @(negedge clk);
        chk_pin(5'(fir_en), 5'h01);
        fir_base = 8'h1f;
        repeat (2) @(negedge clk);
        chk_pin(5'(fir_en), 5'h00);
        // two 100 us steps at ten cycles each
        wr_m(0, 8'h02);
        pulse(to_start);
        n = 0;
        while (to_exp !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk_pin(5'(n >= 18 && n <= 26), 5'h01);
        wr_m(4, 8'hce);
        do_rst(1'b1);
        for (int i = 0; i < 5; i++) rd_m(i);
        do_rst(1'b0);
        for (int i = 0; i < 5; i++) rd_m(i);
        summarize();
    end
endmodule // test_ir_runtime_gpio_config_regs
